// [rtl/flash_seq_pkg.sv]
/*
 Constants and types shared by the flash row self-write sequencer.
 Assumes a 20 MHz system clock and a 32-bit AXI4-Lite register port.
*/
package flash_seq_pkg;
  // ------------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_KEY     = 8'h04;
  localparam logic [7:0] OFS_ADDR_LO = 8'h08;
  localparam logic [7:0] OFS_ADDR_HI = 8'h0C;
  localparam logic [7:0] OFS_DATA_LO = 8'h10;
  localparam logic [7:0] OFS_DATA_HI = 8'h14;
  // ------------------------------------------------------------------
  // Control register fields
  // ------------------------------------------------------------------
  localparam int BIT_WR_START   = 1;
  localparam int BIT_PROG_EN    = 2;
  localparam int BIT_ERASE_SEL  = 4;
  localparam int BIT_LATCH_ONLY = 5;
  localparam logic [7:0] CTRL_FIXED_ONES = 8'h80;
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  // ------------------------------------------------------------------
  // Geometry and timing
  // ------------------------------------------------------------------
  localparam int ADDR_W   = 13;
  localparam int DATA_W   = 14;
  localparam int ROW_BITS = 5;
  localparam int ROW_WORDS = 32;
  localparam int CLK_NS   = 50;
  localparam int SETUP_CYC = 2;
  localparam int T_OP_US   = 4000;
  localparam int OP_CYC    = T_OP_US * 1000 / CLK_NS;
  localparam int T_PWRT_MS = 64;
  localparam int PWRT_CYC  = T_PWRT_MS * 1000 * (1000 / CLK_NS);
  // Protected upper bound per write-protect setting (exclusive)
  localparam logic [13:0] WP_LIM_0 = 14'h1000;
  localparam logic [13:0] WP_LIM_1 = 14'h0800;
  localparam logic [13:0] WP_LIM_2 = 14'h0200;
  localparam logic [13:0] WP_LIM_3 = 14'h0000;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {OP_LATCH, OP_ERASE, OP_COMMIT} op_type;

  typedef struct packed {
    logic                      erase;
    logic                      write;
    logic [ADDR_W-ROW_BITS-1:0] row;
    logic [ROW_BITS-1:0]       word;
    logic [DATA_W-1:0]         data;
  } flash_cmd_type;
endpackage : flash_seq_pkg

// [rtl/flash_row_self_write_sequencer.sv]
/*
 Flash row self-write sequencer: unlock check, row latches, erase and
 commit sequencing, processor stall and no-op forcing.
 Assumes an AXI4-Lite master on the system clock and a flash array that
 accepts one erase or one word write per command strobe.
*/
module flash_row_self_write_sequencer #(
  parameter int OP_CYCLES   = flash_seq_pkg::OP_CYC,
  parameter int PWRT_CYCLES = flash_seq_pkg::PWRT_CYC
) (
  input  wire logic                         clk,
  input  wire logic                         nrst,
  input  wire logic [7:0]                   s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output wire logic                         s_axi_awready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output wire logic                         s_axi_wready,
  output      logic [1:0]                   s_axi_bresp,
  output      logic                         s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [7:0]                   s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output wire logic                         s_axi_arready,
  output      logic [31:0]                  s_axi_rdata,
  output      logic [1:0]                   s_axi_rresp,
  output      logic                         s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  input  wire logic [1:0]                   write_protect_field,
  input  wire logic                         debug_halt,
  output      flash_seq_pkg::flash_cmd_type flash_cmd,
  output wire logic                         cpu_stall,
  output wire logic                         force_nop,
  output wire logic                         high_power_mode
);
  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_PROG, ST_WAIT} state_type;

  // ------------------------------------------------------------------
  // Protection check
  // ------------------------------------------------------------------
  function automatic logic is_protected(input logic [1:0] wp,
                                        input logic [12:0] a);
    logic [13:0] lim;
    lim = flash_seq_pkg::WP_LIM_3;
    unique case (wp)
      2'h0: lim = flash_seq_pkg::WP_LIM_0;
      2'h1: lim = flash_seq_pkg::WP_LIM_1;
      2'h2: lim = flash_seq_pkg::WP_LIM_2;
      2'h3: lim = flash_seq_pkg::WP_LIM_3;
    endcase
    return {1'b0, a} < lim;
  endfunction : is_protected

  state_type                    state_r;
  flash_seq_pkg::op_type        op_r;
  logic [4:0]                   addr_hi_r;
  logic [7:0]                   addr_lo_r;
  logic [5:0]                   data_hi_r;
  logic [7:0]                   data_lo_r;
  logic                         prog_en_r;
  logic                         erase_sel_r;
  logic                         latch_only_r;
  logic                         wr_r;
  logic [1:0]                   key_r;
  logic [31:0]                  cnt_r;
  logic [31:0]                  pwrt_r;
  logic [13:0]                  latch_mem [flash_seq_pkg::ROW_WORDS];
  logic                         rd_key_r;

  // ------------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------------
  wire       wr_fire   = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  wire       rd_fire   = s_axi_arvalid & ~s_axi_rvalid;
  wire       wr_lane   = wr_fire & s_axi_wstrb[0];
  wire [7:0] wd        = s_axi_wdata[7:0];
  wire       sel_ctrl  = s_axi_awaddr == flash_seq_pkg::OFS_CTRL;
  wire       sel_key   = s_axi_awaddr == flash_seq_pkg::OFS_KEY;
  wire       sel_alo   = s_axi_awaddr == flash_seq_pkg::OFS_ADDR_LO;
  wire       sel_ahi   = s_axi_awaddr == flash_seq_pkg::OFS_ADDR_HI;
  wire       sel_dlo   = s_axi_awaddr == flash_seq_pkg::OFS_DATA_LO;
  wire       sel_dhi   = s_axi_awaddr == flash_seq_pkg::OFS_DATA_HI;
  wire       wr_mapped = sel_ctrl | sel_key | sel_alo | sel_ahi | sel_dlo | sel_dhi;
  wire       pwrt_done = pwrt_r == 32'h0;
  wire       idle      = state_r == ST_IDLE;
  wire [12:0] word_addr = {addr_hi_r, addr_lo_r};
  wire [7:0]  row_addr  = word_addr[12:flash_seq_pkg::ROW_BITS];
  wire [4:0]  latch_idx = word_addr[flash_seq_pkg::ROW_BITS-1:0];
  wire        armed     = key_r == 2'h2;
  wire        start_req = wr_lane & sel_ctrl & wd[flash_seq_pkg::BIT_WR_START];
  wire        start     = start_req & armed & idle & prog_en_r
                          & pwrt_done
                          & ~is_protected(write_protect_field, word_addr);
  wire        start_erase = wd[flash_seq_pkg::BIT_ERASE_SEL];
  wire        start_latch = wd[flash_seq_pkg::BIT_LATCH_ONLY];
  wire        setup_done  = state_r == ST_SETUP && cnt_r == 32'h1;
  wire        prog_last   = state_r == ST_PROG && cnt_r == 32'h1F;
  wire        wait_done   = state_r == ST_WAIT && cnt_r == 32'h1;

  assign s_axi_awready = wr_fire;
  assign s_axi_wready  = wr_fire;
  assign s_axi_arready = rd_fire;

  // ------------------------------------------------------------------
  // Unlock sequence tracker
  // ------------------------------------------------------------------
  wire [1:0] key_nxt =
    debug_halt                                       ? 2'h0 :
    !wr_fire                                         ? key_r :
    (sel_key && wd == flash_seq_pkg::KEY_FIRST)       ? 2'h1 :
    (sel_key && key_r == 2'h1 && wd == flash_seq_pkg::KEY_SECOND) ? 2'h2 :
    2'h0;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      key_r <= 2'h0;
    else
      key_r <= key_nxt;
  end

  // ------------------------------------------------------------------
  // Power-up timer
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      pwrt_r <= 32'(PWRT_CYCLES);
    else if (!pwrt_done)
      pwrt_r <= pwrt_r - 32'h1;
  end

  // ------------------------------------------------------------------
  // Software registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      addr_hi_r    <= 5'h00;
      addr_lo_r    <= 8'h00;
      data_hi_r    <= 6'h00;
      data_lo_r    <= 8'h00;
      prog_en_r    <= 1'b0;
      erase_sel_r  <= 1'b0;
      latch_only_r <= 1'b0;
    end
    else
    begin
      if (wr_lane && sel_alo)
        addr_lo_r <= wd;
      if (wr_lane && sel_ahi)
        addr_hi_r <= wd[4:0];
      if (wr_lane && sel_dlo)
        data_lo_r <= wd;
      if (wr_lane && sel_dhi)
        data_hi_r <= wd[5:0];
      if (wr_lane && sel_ctrl)
      begin
        prog_en_r    <= wd[flash_seq_pkg::BIT_PROG_EN];
        erase_sel_r  <= wd[flash_seq_pkg::BIT_ERASE_SEL];
        latch_only_r <= wd[flash_seq_pkg::BIT_LATCH_ONLY];
      end
      else if (wait_done && op_r == flash_seq_pkg::OP_ERASE)
        erase_sel_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Write-start bit: set by software only, cleared on completion
  // ------------------------------------------------------------------
  wire op_end = wait_done || (setup_done && op_r == flash_seq_pkg::OP_LATCH);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      wr_r <= 1'b0;
    else if (start)
      wr_r <= 1'b1;
    else if (op_end)
      wr_r <= 1'b0;
  end

  // ------------------------------------------------------------------
  // Operation sequencer
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r <= ST_IDLE;
      op_r    <= flash_seq_pkg::OP_LATCH;
      cnt_r   <= 32'h0;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE:
          if (start)
          begin
            state_r <= ST_SETUP;
            cnt_r   <= 32'(flash_seq_pkg::SETUP_CYC);
            op_r    <= start_erase ? flash_seq_pkg::OP_ERASE  :
                       start_latch ? flash_seq_pkg::OP_LATCH  :
                                     flash_seq_pkg::OP_COMMIT;
          end
        ST_SETUP:
          if (setup_done)
          begin
            unique case (op_r)
              flash_seq_pkg::OP_LATCH:
                state_r <= ST_IDLE;
              flash_seq_pkg::OP_ERASE:
              begin
                state_r <= ST_WAIT;
                cnt_r   <= 32'(OP_CYCLES);
              end
              default:
              begin
                state_r <= ST_PROG;
                cnt_r   <= 32'h0;
              end
            endcase
          end
          else
            cnt_r <= cnt_r - 32'h1;
        ST_PROG:
          if (prog_last)
          begin
            state_r <= ST_WAIT;
            cnt_r   <= 32'(OP_CYCLES);
          end
          else
            cnt_r <= cnt_r + 32'h1;
        ST_WAIT:
          if (wait_done)
            state_r <= ST_IDLE;
          else
            cnt_r <= cnt_r - 32'h1;
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Row latches
  // ------------------------------------------------------------------
  wire latch_load = (setup_done && op_r != flash_seq_pkg::OP_ERASE);

  always_ff @(posedge clk)
  begin
    if (latch_load)
      latch_mem[latch_idx] <= {data_hi_r, data_lo_r};
  end

  // ------------------------------------------------------------------
  // Flash array commands
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      flash_cmd <= '0;
    else
    begin
      flash_cmd.erase <= setup_done && op_r == flash_seq_pkg::OP_ERASE;
      flash_cmd.write <= state_r == ST_PROG;
      flash_cmd.row   <= row_addr;
      flash_cmd.word  <= state_r == ST_PROG ? cnt_r[4:0] : 5'h00;
      flash_cmd.data  <= state_r == ST_PROG ? latch_mem[cnt_r[4:0]] : 14'h0000;
    end
  end

  wire busy_op = !idle && op_r != flash_seq_pkg::OP_LATCH;
  assign force_nop       = state_r == ST_SETUP;
  assign cpu_stall       = busy_op;
  assign high_power_mode = !idle;

  // ------------------------------------------------------------------
  // Bus responses
  // ------------------------------------------------------------------
  wire [7:0] ctrl_rd = flash_seq_pkg::CTRL_FIXED_ONES
                       | ({7'h00, latch_only_r} << flash_seq_pkg::BIT_LATCH_ONLY)
                       | ({7'h00, erase_sel_r} << flash_seq_pkg::BIT_ERASE_SEL)
                       | ({7'h00, prog_en_r} << flash_seq_pkg::BIT_PROG_EN)
                       | ({7'h00, wr_r} << flash_seq_pkg::BIT_WR_START);
  wire       rd_key  = s_axi_araddr == flash_seq_pkg::OFS_KEY;
  wire       rd_map  = rd_key
                       || s_axi_araddr == flash_seq_pkg::OFS_CTRL
                       || s_axi_araddr == flash_seq_pkg::OFS_ADDR_LO
                       || s_axi_araddr == flash_seq_pkg::OFS_ADDR_HI
                       || s_axi_araddr == flash_seq_pkg::OFS_DATA_LO
                       || s_axi_araddr == flash_seq_pkg::OFS_DATA_HI;
  wire [7:0] rd_val  =
    s_axi_araddr == flash_seq_pkg::OFS_CTRL    ? ctrl_rd :
    s_axi_araddr == flash_seq_pkg::OFS_ADDR_LO ? addr_lo_r :
    s_axi_araddr == flash_seq_pkg::OFS_ADDR_HI ? {3'h0, addr_hi_r} :
    s_axi_araddr == flash_seq_pkg::OFS_DATA_LO ? data_lo_r :
    s_axi_araddr == flash_seq_pkg::OFS_DATA_HI ? {2'h0, data_hi_r} :
    8'h00;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= flash_seq_pkg::RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= flash_seq_pkg::RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
      rd_key_r     <= 1'b0;
    end
    else
    begin
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? flash_seq_pkg::RESP_OKAY : flash_seq_pkg::RESP_DECERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (rd_fire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, rd_val};
        s_axi_rresp  <= rd_map ? flash_seq_pkg::RESP_OKAY : flash_seq_pkg::RESP_DECERR;
        rd_key_r     <= rd_key;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_setup;
    force_nop [*2] ##1 !force_nop;
  endsequence

  property p_prot;
    (flash_cmd.erase || flash_cmd.write)
      |-> !is_protected(write_protect_field, {flash_cmd.row, 5'h00});
  endproperty
  a_prot: assert property (p_prot) else $error("protected row modified");

  property p_setup;
    start |=> s_setup;
  endproperty
  a_setup: assert property (p_setup) else $error("setup not two cycles");

  property p_enable;
    start |-> prog_en_r && pwrt_done;
  endproperty
  a_enable: assert property (p_enable) else $error("start while disabled");

  property p_pwrt;
    !pwrt_done |-> !start && idle;
  endproperty
  a_pwrt: assert property (p_pwrt) else $error("write during power-up");

  property p_key;
    start |-> $past(key_r) != 2'h0 && key_r == 2'h2;
  endproperty
  a_key: assert property (p_key) else $error("start without unlock");

  property p_latch;
    (start && start_latch && !start_erase) |=> (!cpu_stall && !flash_cmd.write) [*3];
  endproperty
  a_latch: assert property (p_latch) else $error("latch load touched array");

  property p_erase;
    (start && start_erase) |=> ##2 flash_cmd.erase && flash_cmd.word == 5'h00 ##1 cpu_stall;
  endproperty
  a_erase: assert property (p_erase) else $error("erase not issued");

  property p_commit;
    (state_r == ST_PROG && cnt_r == 32'h0) |=> flash_cmd.write && flash_cmd.word == 5'h00
      ##31 flash_cmd.word == 5'h1F ##1 !flash_cmd.write;
  endproperty
  a_commit: assert property (p_commit) else $error("row write not 32 words");

  property p_no_erase;
    op_r == flash_seq_pkg::OP_COMMIT |-> !flash_cmd.erase;
  endproperty
  a_no_erase: assert property (p_no_erase) else $error("write erased row");

  property p_power;
    cpu_stall |-> high_power_mode;
  endproperty
  a_power: assert property (p_power) else $error("stall in low power");

  property p_key_read;
    (s_axi_rvalid && rd_key_r) |-> s_axi_rdata == 32'h0;
  endproperty
  a_key_read: assert property (p_key_read) else $error("key reads nonzero");

  property p_wr_clear;
    $fell(wr_r) |-> idle;
  endproperty
  a_wr_clear: assert property (p_wr_clear) else $error("start bit cleared early");
endmodule : flash_row_self_write_sequencer

// [tb/flash_array_model.sv]
/*
 Behavioural program flash array for the sequencer bench.
 Assumes one erase pulse per row and one word write per write pulse.
*/
module flash_array_model
(
  input wire logic                         clk,
  input wire flash_seq_pkg::flash_cmd_type cmd
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------------
  // Storage and event counters
  // ------------------------------------------------------------------
  logic [13:0] mem [0:8191];
  int          erase_cnt = 0;
  int          write_cnt = 0;
  int          order_bad = 0;
  logic [7:0]  last_row;
  initial
  begin
    for (int i = 0; i < 8192; i++) mem[i] = 14'h0000;
  end
  always @(posedge clk)
  begin
    if (cmd.erase === 1'b1)
    begin
      last_row <= cmd.row;
      erase_cnt <= erase_cnt + 1;
      for (int i = 0; i < 32; i++) mem[{cmd.row, 5'(i)}] <= 14'h3FFF;
    end
    if (cmd.write === 1'b1)
    begin
      // Programming only clears bits, so a missing erase shows
      mem[{cmd.row, cmd.word}] <= mem[{cmd.row, cmd.word}] & cmd.data;
      if (cmd.word !== 5'(write_cnt)) order_bad <= order_bad + 1;
      write_cnt <= write_cnt + 1;
    end
  end
endmodule : flash_array_model

// [tb/flash_row_self_write_sequencer_tb_top.sv]
/*
 Self-checking bench: AXI4-Lite register tasks drive unlock, erase,
 latch and commit sequences. Assumes the sequencer and flash_seq_pkg.
*/
`define CHK(g, e, m) begin checked++; if ((g) !== (e)) begin errors++; \
  $display("wrong value at %0t: %s", $time, m); end end
module flash_row_self_write_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic clk = 0, nrst = 0, awvalid = 0, wvalid = 0, bready = 1, arvalid = 0;
  logic rready = 1, dbg = 0, awready, wready, bvalid, arready, rvalid;
  logic stall, nop, hp;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp, wp = 2'h3, resp;
  logic [7:0] rd;
  flash_seq_pkg::flash_cmd_type cmd;
  int errors = 0, checked = 0, nop_cnt = 0, stall_cnt = 0, hp_cnt = 0, e0;
  initial forever #25 clk = ~clk;
  flash_row_self_write_sequencer #(.OP_CYCLES(20), .PWRT_CYCLES(10)) i_dut (
    .clk(clk), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .write_protect_field(wp), .debug_halt(dbg), .flash_cmd(cmd),
    .cpu_stall(stall), .force_nop(nop), .high_power_mode(hp));
  flash_array_model i_flash (.clk(clk), .cmd(cmd));
  always @(posedge clk)
  begin
    nop_cnt <= nop_cnt + int'(nop === 1'b1);
    stall_cnt <= stall_cnt + int'(stall === 1'b1);
    hp_cnt <= hp_cnt + int'(hp === 1'b1);
  end
  // ------------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1; wvalid <= 1;
    do @(posedge clk); while (awready !== 1'b1);
    awvalid <= 0; wvalid <= 0;
    do @(posedge clk); while (bvalid !== 1'b1);
    resp = bresp;
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    araddr <= a; arvalid <= 1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rd = rdata[7:0]; resp = rresp;
  endtask : rdr
  // Start write is followed only by polling, which stands in for the two no-ops
  task automatic seq(input logic [7:0] pre, input logic [7:0] go);
    wr(8'h00, pre); wr(8'h04, 8'h55); wr(8'h04, 8'hAA); wr(8'h00, go);
  endtask : seq
  task automatic done();
    for (int i = 0; i < 300; i++) begin rdr(8'h00); if (rd[1] === 1'b0) break; end
  endtask : done
  task automatic conclude();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  // ------------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge clk);
    nrst <= 1;
    repeat (12) @(posedge clk);
    rdr(8'h00); `CHK(rd, 8'h80, "control after reset")
    rdr(8'h04); `CHK(rd, 8'h00, "unlock reads")
    rdr(8'h40); `CHK(resp, 2'h3, "unmapped read")
    wr(8'h40, 8'h01); `CHK(resp, 2'h3, "unmapped write")
    wr(8'h08, 8'h34); wr(8'h0C, 8'h12); `CHK(resp, 2'h0, "mapped write")
    e0 = i_flash.erase_cnt;
    seq(8'h10, 8'h12); done(); `CHK(i_flash.erase_cnt, e0, "erase with enable low")
    wr(8'h00, 8'h14); wr(8'h04, 8'h55); wr(8'h08, 8'h34); wr(8'h04, 8'hAA);
    wr(8'h00, 8'h16); done(); `CHK(i_flash.erase_cnt, e0, "broken unlock")
    wr(8'h04, 8'h55); wr(8'h04, 8'hAA); dbg <= 1; @(posedge clk); dbg <= 0;
    wr(8'h00, 8'h16); done(); `CHK(i_flash.erase_cnt, e0, "debug break")
    $display("test refusals done");
    nop_cnt = 0; stall_cnt = 0; hp_cnt = 0;
    seq(8'h14, 8'h16); done();
    `CHK(i_flash.erase_cnt, e0 + 1, "erase count")
    `CHK(i_flash.last_row, 8'h91, "erase row")
    `CHK(nop_cnt, 2, "forced no-ops")
    `CHK(stall_cnt, 22, "erase stall")
    `CHK(hp_cnt > 0, 1'b1, "high power")
    `CHK(rd, 8'h84, "start and erase bits clear")
    $display("test erase done");
    stall_cnt = 0;
    for (int i = 0; i < 31; i++)
    begin
      wr(8'h08, 8'h20 + 8'(i)); wr(8'h10, ~8'(i)); wr(8'h14, 8'(i));
      seq(8'h24, 8'h26); done();
    end
    `CHK(i_flash.write_cnt, 0, "latch loads write nothing")
    `CHK(stall_cnt, 0, "latch loads without stall")
    wr(8'h08, 8'h3F); wr(8'h10, 8'hE0); wr(8'h14, 8'h1F);
    seq(8'h04, 8'h06); done();
    `CHK(i_flash.write_cnt, 32, "commit words")
    `CHK(i_flash.order_bad, 0, "commit order")
    `CHK(i_flash.erase_cnt, e0 + 1, "no erase in commit")
    `CHK(stall_cnt > 32, 1'b1, "commit stall")
    for (int i = 0; i < 32; i++)
      `CHK(i_flash.mem[13'h1220 + 13'(i)], {6'(i), ~8'(i)}, "row contents")
    $display("test row write done");
    wp <= 2'h0; wr(8'h08, 8'h40); wr(8'h0C, 8'h00);
    seq(8'h14, 8'h16); done();
    `CHK(i_flash.erase_cnt, e0 + 1, "protected row")
    `CHK(rd[1], 1'b0, "protected start ignored")
    $display("test protection done");
    conclude();
  end
  initial
  begin
    #2000000;
    errors++;
    conclude();
  end
endmodule : flash_row_self_write_sequencer_tb_top
